// *** pkg/bmla_defs.svh ***
/*
 * Constants for the decimal, multiply/divide, logic and jump datapath.
 * Assumes inclusion by bare name from the datapath module and the testbench.
 */
// Operation
// - bcd fixup adds six when low nibble above nine or half carry set.
// - low-nibble correction may set carry but never clears it.
// - then add six to high nibble if carry set or nibble above nine.
// - final carry is old carry or carry out of either six-addition.
// - product op puts low byte in accumulator, high byte in second operand.
// - product op clears signed range flag when high byte zero, else sets.
// - quotient op returns quotient in accumulator, remainder in second op.
// - divide by zero sets signed range flag; nonzero divisor clears it.
// - bitwise and/or/xor write first operand, leave all flags unchanged.
// - bitwise ops accept direct byte destination with acc or immediate.
// - far branch target is full 16 bits from instruction bytes two, three.
// - block branch takes bits 10..8 from opcode, bits 7..0 from byte two.
// - block branch keeps upper bits from the incremented program counter.
// - relative branch target is incremented pc plus sign-extended offset.
// - relative branch with zero displacement continues at next instruction.
// - sums set carry from bit seven, half carry from bit three.
// - sums and borrow-difference set signed range flag as c6 xor c7.
`ifndef BMLA_DEFS_SVH
`define BMLA_DEFS_SVH
`define BMLA_NIBBLE_MAX     4'h9
`define BMLA_SIX            8'h06
`define BMLA_SIX_HI         8'h60
`define BMLA_DIV0_ACC       8'hFF
// nonzero: sec has no load path, so divide by zero reseeds it
`define BMLA_DIV0_SEC       8'hFF
`define BMLA_BLOCK_LSB      11
`define BMLA_ACC_RST        8'h00
`define BMLA_SEC_RST        8'h00
`define BMLA_PC_RST         16'h0000
`endif

// *** pkg/bmla_pkg.sv ***
/*
 * Types for the datapath: operation codes and operand source selection.
 * Assumes the sequencer drives one operation code per cycle.
 */
package bmla_pkg;
	typedef enum logic [3:0] {
		BMLA_NOP,
		BMLA_SUM,
		BMLA_SUM_CARRY,
		BMLA_DIFF_BORROW,
		BMLA_BCD_FIXUP,
		BMLA_PRODUCT,
		BMLA_QUOTIENT,
		BMLA_AND,
		BMLA_OR,
		BMLA_XOR,
		BMLA_FAR_BRANCH,
		BMLA_BLOCK_BRANCH,
		BMLA_REL_BRANCH
	} bmla_op_t;
	typedef enum logic [1:0] {
		BMLA_DST_ACC,
		BMLA_DST_DIRECT
	} bmla_dst_t;
	typedef enum logic {
		BMLA_SRC_ACC,
		BMLA_SRC_OPERAND
	} bmla_src_t;
endpackage

// *** rtl/bmla_alu.sv ***
/*
 * Execution datapath: decimal fixup, add/subtract flags, 8x8 multiply,
 * 8/8 divide, bytewise logic and unconditional jump targets.
 * Assumes the sequencer supplies operands, the incremented program
 * counter and instruction bytes, and holds OP valid for one cycle.
 */
`timescale 1ns/100ps
`include "bmla_defs.svh"
module bmla_alu
	import bmla_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// operation request
	input  wire logic        OP_VALID,
	input  wire bmla_op_t    OP,
	input  wire bmla_dst_t   DST_SEL,
	input  wire bmla_src_t   SRC_SEL,
	input  wire logic [7:0]  OPERAND,
	input  wire logic [7:0]  DIRECT_IN,
	// program counter and instruction bytes
	input  wire logic [15:0] PC_INC,
	input  wire logic [2:0]  OPC_FIELD,
	input  wire logic [7:0]  INSN_BYTE2,
	input  wire logic [7:0]  INSN_BYTE3,
	// register file results
	output logic [7:0]       ACC,
	output logic [7:0]       SEC,
	output logic [7:0]       DIRECT_OUT,
	output logic             DIRECT_WE,
	// flags
	output logic             CARRY,
	output logic             HALF_CARRY,
	output logic             SIGNED_RANGE,
	// branch target
	output logic [15:0]      BRANCH_TARGET,
	output logic             BRANCH_TAKE
);

	initial begin
		if (WIDTH != 8)
			$error("bmla_alu serves 8-bit data only");
	end

	logic       rst_meta;
	logic       rst_n;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// adder shared by sums and borrow-difference
	logic [7:0] add_b;
	logic       add_cin;
	logic [4:0] add_lo;
	logic [7:0] add_low7;
	logic [8:0] add_full;
	logic       c3;
	logic       c6;
	logic       c7;
	always_comb begin
		add_b   = OPERAND;
		add_cin = 1'b0;
		if (OP == BMLA_SUM_CARRY)
			add_cin = CARRY;
		if (OP == BMLA_DIFF_BORROW) begin
			add_b   = ~OPERAND;
			add_cin = ~CARRY;
		end
		add_lo   = {1'b0, ACC[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
		add_low7 = {1'b0, ACC[6:0]} + {1'b0, add_b[6:0]} + {7'h00, add_cin};
		add_full = {1'b0, ACC} + {1'b0, add_b} + {8'h00, add_cin};
		c3 = add_lo[4];
		c6 = add_low7[7];
		c7 = add_full[8];
	end

	// decimal fixup in two steps
	logic [8:0] dec_lo;
	logic [8:0] dec_hi;
	logic       dec_carry;
	always_comb begin
		dec_lo = {1'b0, ACC};
		if (ACC[3:0] > `BMLA_NIBBLE_MAX || HALF_CARRY)
			dec_lo = {1'b0, ACC} + {1'b0, `BMLA_SIX};
		// carry only ever ORed in, so a set carry survives
		dec_carry = CARRY | dec_lo[8];
		dec_hi = {1'b0, dec_lo[7:0]};
		if (dec_carry || dec_lo[7:4] > `BMLA_NIBBLE_MAX)
			dec_hi = {1'b0, dec_lo[7:0]} + {1'b0, `BMLA_SIX_HI};
	end

	// single-cycle multiply and divide; area traded for latency
	logic [15:0] prod;
	logic [7:0]  quot;
	logic [7:0]  rem;
	always_comb begin
		prod = {8'h00, ACC} * {8'h00, SEC};
		quot = `BMLA_DIV0_ACC;
		rem  = `BMLA_DIV0_SEC;
		if (SEC != 8'h00) begin
			quot = ACC / SEC;
			rem  = ACC % SEC;
		end
	end

	// bytewise logic
	logic [7:0] logic_a;
	logic [7:0] logic_b;
	logic [7:0] logic_r;
	always_comb begin
		logic_a = (DST_SEL == BMLA_DST_DIRECT) ? DIRECT_IN : ACC;
		logic_b = (SRC_SEL == BMLA_SRC_ACC) ? ACC : OPERAND;
		unique case (OP)
			BMLA_AND: logic_r = logic_a & logic_b;
			BMLA_OR:  logic_r = logic_a | logic_b;
			default:  logic_r = logic_a ^ logic_b;
		endcase
	end
	logic is_logic;
	assign is_logic = (OP == BMLA_AND) || (OP == BMLA_OR) ||
		(OP == BMLA_XOR);

	// accumulator and second operand
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ACC <= `BMLA_ACC_RST;
			SEC <= `BMLA_SEC_RST;
		end else if (OP_VALID) begin
			unique case (OP)
				BMLA_SUM, BMLA_SUM_CARRY, BMLA_DIFF_BORROW:
					ACC <= add_full[7:0];
				BMLA_BCD_FIXUP:
					ACC <= dec_hi[7:0];
				BMLA_PRODUCT: begin
					ACC <= prod[7:0];
					SEC <= prod[15:8];
				end
				BMLA_QUOTIENT: begin
					ACC <= quot;
					SEC <= rem;
				end
				BMLA_AND, BMLA_OR, BMLA_XOR: begin
					if (DST_SEL == BMLA_DST_ACC)
						ACC <= logic_r;
				end
				default: ;
			endcase
		end
	end

	// direct-address writeback of bytewise ops
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			DIRECT_OUT <= 8'h00;
			DIRECT_WE  <= 1'b0;
		end else begin
			DIRECT_WE  <= OP_VALID && is_logic &&
				DST_SEL == BMLA_DST_DIRECT;
			DIRECT_OUT <= logic_r;
		end
	end

	// flags; bytewise ops and jumps leave them alone
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			CARRY        <= 1'b0;
			HALF_CARRY   <= 1'b0;
			SIGNED_RANGE <= 1'b0;
		end else if (OP_VALID) begin
			unique case (OP)
				BMLA_SUM, BMLA_SUM_CARRY: begin
					CARRY        <= c7;
					HALF_CARRY   <= c3;
					SIGNED_RANGE <= c6 ^ c7;
				end
				BMLA_DIFF_BORROW: begin
					CARRY        <= ~c7;
					HALF_CARRY   <= ~c3;
					SIGNED_RANGE <= c6 ^ c7;
				end
				BMLA_BCD_FIXUP:
					CARRY <= dec_carry | dec_hi[8];
				BMLA_PRODUCT: begin
					CARRY        <= 1'b0;
					SIGNED_RANGE <= (prod[15:8] != 8'h00);
				end
				BMLA_QUOTIENT: begin
					CARRY        <= 1'b0;
					SIGNED_RANGE <= (SEC == 8'h00);
				end
				default: ;
			endcase
		end
	end

	// jump target calculation
	logic [15:0] rel_target;
	assign rel_target = PC_INC + {{8{INSN_BYTE2[7]}}, INSN_BYTE2};

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			BRANCH_TARGET <= `BMLA_PC_RST;
			BRANCH_TAKE   <= 1'b0;
		end else begin
			BRANCH_TAKE <= OP_VALID && (OP == BMLA_FAR_BRANCH ||
				OP == BMLA_BLOCK_BRANCH || OP == BMLA_REL_BRANCH);
			if (OP_VALID) begin
				unique case (OP)
					BMLA_FAR_BRANCH:
						BRANCH_TARGET <= {INSN_BYTE2, INSN_BYTE3};
					BMLA_BLOCK_BRANCH:
						BRANCH_TARGET <= {PC_INC[15:`BMLA_BLOCK_LSB],
							OPC_FIELD, INSN_BYTE2};
					BMLA_REL_BRANCH:
						BRANCH_TARGET <= rel_target;
					default: ;
				endcase
			end
		end
	end

	// checks
	property p_bcd_low;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_BCD_FIXUP && ACC[3:0] < 4'hA && !HALF_CARRY
			&& !CARRY && ACC[7:4] < 4'hA)
		|=> ACC == $past(ACC);
	endproperty
	a_bcd_low: assert property (p_bcd_low) else $error("bcd changed digit");

	property p_bcd_carry_keep;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_BCD_FIXUP && CARRY) |=> CARRY;
	endproperty
	a_bcd_carry_keep: assert property (p_bcd_carry_keep) else $error("bcd cleared carry");

	property p_bcd_hi;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_BCD_FIXUP) |=> ACC[7:4] <= 4'h9 || CARRY;
	endproperty
	a_bcd_hi: assert property (p_bcd_hi) else $error("bcd high digit bad");

	property p_product;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_PRODUCT) |=>
			{SEC, ACC} == $past(ACC) * $past(SEC) &&
			SIGNED_RANGE == (SEC != 8'h00);
	endproperty
	a_product: assert property (p_product) else $error("product wrong");

	property p_quotient;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_QUOTIENT && SEC != 8'h00) |=>
			!SIGNED_RANGE && SEC < $past(SEC) &&
			ACC * $past(SEC) + SEC == $past(ACC);
	endproperty
	a_quotient: assert property (p_quotient) else $error("quotient wrong");

	property p_div_zero;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_QUOTIENT && SEC == 8'h00) |=>
			SIGNED_RANGE && ACC == `BMLA_DIV0_ACC && SEC == `BMLA_DIV0_SEC;
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("div zero wrong");

	property p_logic_flags;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && is_logic) |=> $stable({CARRY, HALF_CARRY, SIGNED_RANGE});
	endproperty
	a_logic_flags: assert property (p_logic_flags) else $error("logic hit flags");

	property p_block;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_BLOCK_BRANCH) |=> BRANCH_TAKE &&
			BRANCH_TARGET[15:11] == $past(PC_INC[15:11]);
	endproperty
	a_block: assert property (p_block) else $error("block target left block");

	property p_rel_zero;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_REL_BRANCH && INSN_BYTE2 == 8'h00) |=>
			BRANCH_TARGET == $past(PC_INC);
	endproperty
	a_rel_zero: assert property (p_rel_zero) else $error("rel zero moved");

	property p_far;
		@(posedge CLK) disable iff (!rst_n)
		(OP_VALID && OP == BMLA_FAR_BRANCH) |=>
			BRANCH_TARGET == {$past(INSN_BYTE2), $past(INSN_BYTE3)};
	endproperty
	a_far: assert property (p_far) else $error("far target wrong");
endmodule

// *** testbench/bmla_seq_model.sv ***
/*
 * Sequencer stand-in: drives one operation request per call.
 * Assumes each call starts just after a rising clk edge.
 */
`timescale 1ns/100ps
module bmla_seq_model
	import bmla_pkg::*;
(
	// clock
	input  wire logic   clk,
	// operation request
	output logic        op_valid,
	output bmla_op_t    op,
	output bmla_dst_t   dst_sel,
	output bmla_src_t   src_sel,
	output logic [7:0]  operand,
	output logic [7:0]  direct_in,
	// instruction context
	output logic [15:0] pc_inc,
	output logic [2:0]  opc_field,
	output logic [7:0]  byte2,
	output logic [7:0]  byte3
);
	initial begin
		op_valid = 1'b0;
		op = BMLA_NOP;
		dst_sel = BMLA_DST_ACC;
		src_sel = BMLA_SRC_ACC;
		{operand, direct_in, pc_inc, opc_field, byte2, byte3} = '0;
	end
	// held through the taking edge, changed only after it
	task automatic issue(input bmla_op_t o, input bmla_dst_t d,
		input bmla_src_t s, input logic [50:0] ctx);
		op_valid <= 1'b1;
		op <= o;
		dst_sel <= d;
		src_sel <= s;
		{operand, direct_in, pc_inc, opc_field, byte2, byte3} <= ctx;
		@(posedge clk);
	endtask
	// idle lines show junk, not the last value
	task automatic idle();
		op_valid <= 1'b0;
		{operand, direct_in, pc_inc, opc_field, byte2, byte3} <=
			~{operand, direct_in, pc_inc, opc_field, byte2, byte3};
		@(posedge clk);
	endtask
endmodule

// *** testbench/tb_bmla_alu.sv ***
/*
 * Self-checking bench: reference model queues expectations per op.
 * Assumes results land one edge after the op is taken.
 */
`timescale 1ns/100ps
`include "bmla_defs.svh"
module tb_bmla_alu
	import bmla_pkg::*;
;
	typedef struct packed {
		logic [7:0]  a, s, d;
		logic        c, h, v, we, bt;
		logic [15:0] t;
	} bmla_exp_t;
	logic CLK, NRST, tk, tk_d;
	wire logic opv;
	wire bmla_op_t op;
	wire bmla_dst_t dst;
	wire bmla_src_t src;
	wire logic [7:0] opnd, din, b2w, b3w, ACC, SEC, DIRECT_OUT;
	wire logic [15:0] pcw, BRANCH_TARGET;
	wire logic [2:0] fld;
	wire logic DIRECT_WE, CARRY, HALF_CARRY, SIGNED_RANGE, BRANCH_TAKE;
	logic [7:0] ra, rs;
	logic rc, rh, rv;
	logic [15:0] rt;
	bmla_exp_t exp_q[$];
	int err_total, n_tests, cyc;
	logic [31:0] seed, r, q;

	bmla_seq_model u_bmla_seq_model(.clk(CLK), .op_valid(opv), .op(op),
		.dst_sel(dst), .src_sel(src), .operand(opnd), .direct_in(din),
		.pc_inc(pcw), .opc_field(fld), .byte2(b2w), .byte3(b3w));
	bmla_alu u_bmla_alu(.CLK(CLK), .NRST(NRST), .OP_VALID(opv), .OP(op),
		.DST_SEL(dst), .SRC_SEL(src), .OPERAND(opnd), .DIRECT_IN(din),
		.PC_INC(pcw), .OPC_FIELD(fld), .INSN_BYTE2(b2w), .INSN_BYTE3(b3w),
		.ACC(ACC), .SEC(SEC), .DIRECT_OUT(DIRECT_OUT),
		.DIRECT_WE(DIRECT_WE), .CARRY(CARRY), .HALF_CARRY(HALF_CARRY),
		.SIGNED_RANGE(SIGNED_RANGE), .BRANCH_TARGET(BRANCH_TARGET),
		.BRANCH_TAKE(BRANCH_TAKE));

	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// reference model, then hand the op to the sequencer
	task automatic step(input bmla_op_t o, input logic [7:0] x = 8'h00,
		input bmla_dst_t d = BMLA_DST_ACC,
		input bmla_src_t s = BMLA_SRC_OPERAND, input logic [7:0] dr = 8'h00,
		input logic [15:0] pc = 16'h0000, input logic [2:0] f = 3'h0,
		input logic [7:0] b2 = 8'h00, input logic [7:0] b3 = 8'h00);
		logic [8:0] t9;
		logic [7:0] t8, fa, sv, rr;
		logic [15:0] p;
		logic ci;
		bmla_exp_t e;
		e = '0;
		ci = rc & (o != BMLA_SUM);
		case (o)
			BMLA_SUM, BMLA_SUM_CARRY: begin
				t9 = ra + x + ci;
				t8 = {1'b0, ra[6:0]} + {1'b0, x[6:0]} + ci;
				rh = ({1'b0, ra[3:0]} + {1'b0, x[3:0]} + ci) > 5'h0F;
				rv = t8[7] ^ t9[8];
				{rc, ra} = t9;
			end
			BMLA_DIFF_BORROW: begin
				t9 = {1'b0, ra} - {1'b0, x} - ci;
				rh = {1'b0, ra[3:0]} < ({1'b0, x[3:0]} + ci);
				rv = (ra[7] ^ x[7]) & (t9[7] ^ ra[7]);
				{rc, ra} = t9;
			end
			BMLA_BCD_FIXUP: begin
				if (ra[3:0] > 4'h9 || rh) begin
					t9 = ra + 8'h06;
					rc |= t9[8];
					ra = t9[7:0];
				end
				if (rc || ra[7:4] > 4'h9) begin
					t9 = ra + 8'h60;
					rc |= t9[8];
					ra = t9[7:0];
				end
			end
			BMLA_PRODUCT: begin
				p = ra * rs;
				{rs, ra} = p;
				rv = |p[15:8];
				rc = 1'b0;
			end
			BMLA_QUOTIENT: begin
				rc = 1'b0;
				rv = (rs == 8'h00);
				rr = rv ? `BMLA_DIV0_ACC : ra / rs;
				rs = rv ? `BMLA_DIV0_SEC : ra % rs;
				ra = rr;
			end
			BMLA_AND, BMLA_OR, BMLA_XOR: begin
				sv = (s == BMLA_SRC_ACC) ? ra : x;
				fa = (d == BMLA_DST_ACC) ? ra : dr;
				rr = (o == BMLA_AND) ? fa & sv : (o == BMLA_OR) ? fa | sv : fa ^ sv;
				if (d == BMLA_DST_ACC)
					ra = rr;
				else
					{e.we, e.d} = {1'b1, rr};
			end
			BMLA_FAR_BRANCH: {e.bt, rt} = {1'b1, b2, b3};
			BMLA_BLOCK_BRANCH: {e.bt, rt} = {1'b1, pc[15:11], f, b2};
			BMLA_REL_BRANCH: {e.bt, rt} = {1'b1, pc + {{8{b2[7]}}, b2}};
			default: ;
		endcase
		{e.a, e.s, e.c, e.h, e.v, e.t} = {ra, rs, rc, rh, rv, rt};
		exp_q.push_back(e);
		u_bmla_seq_model.issue(o, d, s, {x, dr, pc, f, b2, b3});
	endtask
	task automatic ld(input logic [7:0] v);
		step(BMLA_AND);
		step(BMLA_OR, v);
	endtask

	always @(posedge CLK) begin
		tk = opv;
		if (tk_d) begin
			chk(ACC, exp_q[0].a);
			chk(SEC, exp_q[0].s);
			chk(CARRY, exp_q[0].c);
			chk(HALF_CARRY, exp_q[0].h);
			chk(SIGNED_RANGE, exp_q[0].v);
			chk(DIRECT_WE, exp_q[0].we);
			if (exp_q[0].we === 1'b1)
				chk(DIRECT_OUT, exp_q[0].d);
			chk(BRANCH_TAKE, exp_q[0].bt);
			chk(BRANCH_TARGET, exp_q[0].t);
			void'(exp_q.pop_front());
		end
		tk_d = tk;
	end
	// ceiling well above the few hundred cycles the run needs
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			close_out();
		end
	end

	initial begin
		{NRST, tk_d, rc, rh, rv, ra, rs, rt} = '0;
		seed = 32'hFBADF591;
		repeat (5) @(posedge CLK);
		NRST <= 1'b1;
		repeat (2) @(posedge CLK);
		for (int i = 0; i < 4; i++) begin
			ld(8'h99 - 8'h41 * i[7:0]);
			step(BMLA_SUM, 8'h01 + 8'h48 * i[7:0]);
			step(BMLA_BCD_FIXUP);
		end
		step(BMLA_QUOTIENT);
		step(BMLA_PRODUCT);
		$display("test decimal and divide done");
		for (int i = 0; i < 5; i++)
			step(BMLA_REL_BRANCH, , , , , 16'h0800, , 8'h7F << (2 * i));
		$display("test relative branch done");
		repeat (400) begin
			r = $random(seed);
			q = $random(seed);
			if (r[31:30] == 2'b11)
				u_bmla_seq_model.idle();
			step(bmla_op_t'(4'h1 + 4'(r % 12)), r[7:0],
				bmla_dst_t'({1'b0, r[8]}), bmla_src_t'(r[9]), r[23:16],
				q[15:0], q[18:16], q[31:24], r[31:24]);
		end
		u_bmla_seq_model.idle();
		repeat (2) @(posedge CLK);
		$display("test random mix done");
		close_out();
	end
endmodule
